// ==== logic/fwp_defines.svh ====
// Constants for the flash array write-protect check
//
// Contract
// - Programming only clears bits; each 256-byte page programs on its own.
// - Erase covers a subsector, a sector or the whole array; erased bits read 1.
// - Array of 32 MB: 512 sectors, 8192 subsectors, 131072 pages from zero.
// - A 64-byte one-time area sits outside the array; array erase never touches it.
// - Modifying commands run only when the clock count is a multiple of eight.
// - A write enable must precede modifying commands; no latch, no execution.
// - While the supply is not yet valid, nothing may be modified.
// - A set sector write-lock bit refuses program and erase on that sector.
// - A set lock-down bit freezes the sector write-lock until reset.
// - Only the lock write command changes locks; ignored when lock-down is set.
// - At power-up every sector starts write-locked.
// - Top/bottom 0: value n of 1..9 guards top 2^(n-1) sectors; 10..15 all.
// - Top/bottom 1: value n of 1..8 guards sectors 0 to 2^(n-1)-1.
// - Top/bottom bit and range guard bits live in the status register.
// - With the write-protect pin low the range guard bits cannot change.
`ifndef FWP_DEFINES_SVH
`define FWP_DEFINES_SVH

`define FWP_ADDR_W 25
`define FWP_SECT_W 9
`define FWP_NUM_SECT 10'h200
`define FWP_SECT_HI 24
`define FWP_SECT_LO 16
`define FWP_SUB_LO 12
`define FWP_SUB_MASK 25'h0000fff
`define FWP_SECT_MASK 25'h000ffff
`define FWP_ADDR_ZERO 25'h0000000
`define FWP_OTP_BYTES 25'h0000040
`define FWP_BYTE_LSB 3'h0
`define FWP_BP_W 4
`define FWP_BP_NONE 4'h0
`define FWP_BP_ONE 4'h1
`define FWP_BP_ALL 4'ha
`define FWP_SPAN_ONE 10'h001
`define FWP_SR_BP_HI 3
`define FWP_SR_BP_LO 0
`define FWP_SR_TB 5
`define FWP_LR_WLOCK 0
`define FWP_LR_LDOWN 1
`define FWP_ERASED 8'hff
`define FWP_BP_RST 4'h0
`define FWP_TB_RST 1'b0
`define FWP_WLOCK_RST 1'b1
`define FWP_LDOWN_RST 1'b0

`endif

// ==== logic/fwp_pkg.sv ====
// Types shared by the write-protect check
package fwp_pkg;

	// Commands as handed over by the serial command decoder
	typedef enum logic [3:0] {
		FWP_OP_NONE,
		FWP_OP_WREN,
		FWP_OP_WRDI,
		FWP_OP_PROG,
		FWP_OP_SSE,
		FWP_OP_SE,
		FWP_OP_CE,
		FWP_OP_OTP,
		FWP_OP_WRSR,
		FWP_OP_WRLR
	} fwp_op_type;

endpackage

// ==== logic/fwp_range_if.sv ====
// Carrier between the guard and its range checker
`timescale 1ns/10ps
`include "fwp_defines.svh"

interface fwp_range_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic tb;
	logic [`FWP_BP_W-1:0] bp;
	logic [`FWP_SECT_W-1:0] sector;
	logic prot;

	modport guard (output tb, output bp, output sector, input prot,
		input clk, input rst_n);
	modport chk (input tb, input bp, input sector, output prot,
		input clk, input rst_n);
endinterface // fwp_range_if

// ==== logic/fwp_range_chk.sv ====
// Block-protect range decode for one sector index
`timescale 1ns/10ps
`include "fwp_defines.svh"

module fwp_range_chk (
	fwp_range_if.chk rif
);
	logic [9:0] span;
	logic [9:0] sect_w;
	logic none_w;
	logic all_w;
	logic top_hit;
	logic bot_hit;

	// Span of 2^(n-1) sectors; only meaningful for n of 1..9
	assign span = `FWP_SPAN_ONE << (rif.bp - `FWP_BP_ONE);
	assign sect_w = {1'b0, rif.sector};
	assign none_w = (rif.bp == `FWP_BP_NONE);
	assign all_w = (rif.bp >= `FWP_BP_ALL);
	assign top_hit = (sect_w >= (`FWP_NUM_SECT - span));
	assign bot_hit = (sect_w < span);
	assign rif.prot = !none_w && (all_w || (rif.tb ? bot_hit : top_hit));

	// Top range at value 1 is the last sector alone
	top_one_a: assert property (@(posedge rif.clk) disable iff (!rif.rst_n)
		(!rif.tb && rif.bp == 4'h1) |-> (rif.prot == (rif.sector == 9'h1ff)))
		else $error("top range of one sector wrong");

	// Bottom range at value 8 covers sectors 0 to 127
	bot_eight_a: assert property (@(posedge rif.clk) disable iff (!rif.rst_n)
		(rif.tb && rif.bp == 4'h8) |-> (rif.prot == (rif.sector < 9'h080)))
		else $error("bottom range of 128 sectors wrong");

	// Large values guard everything, zero guards nothing
	all_none_a: assert property (@(posedge rif.clk) disable iff (!rif.rst_n)
		(rif.bp >= 4'ha) || (rif.bp == 4'h0) |->
		(rif.prot == (rif.bp != 4'h0)))
		else $error("full or empty range decode wrong");
endmodule // fwp_range_chk

// ==== logic/fwp_guard.sv ====
// Write-protect check between command decoder and program/erase engine
`timescale 1ns/10ps
`include "fwp_defines.svh"

module fwp_guard #(
	parameter int unsigned SECTORS = `FWP_NUM_SECT,
	parameter int unsigned CNT_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic supply_ok_i,
	input wire logic wp_n_i,
	input wire logic cmd_valid_i,
	input wire fwp_pkg::fwp_op_type cmd_op_i,
	input wire logic [`FWP_ADDR_W-1:0] cmd_addr_i,
	input wire logic [CNT_W-1:0] cmd_bits_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic [7:0] old_byte_i,
	output logic grant_o,
	output logic refuse_o,
	output fwp_pkg::fwp_op_type grant_op_o,
	output logic [`FWP_ADDR_W-1:0] grant_addr_o,
	output logic [7:0] new_byte_o,
	output logic wel_o,
	output logic top_bottom_o,
	output logic [`FWP_BP_W-1:0] range_guard_bits_o,
	output logic [1:0] lock_state_o
);

	// The lock array is sized to the fixed sector map
	if (SECTORS != `FWP_NUM_SECT) begin : g_sect_chk
		$error("SECTORS must match the array sector count");
	end
	if (CNT_W < 3) begin : g_cnt_chk
		$error("CNT_W too narrow to hold a byte count");
	end

	// Commands that touch the main array
	function automatic logic is_array(input fwp_pkg::fwp_op_type op);
		is_array = (op == fwp_pkg::FWP_OP_PROG) ||
			(op == fwp_pkg::FWP_OP_SSE) ||
			(op == fwp_pkg::FWP_OP_SE) ||
			(op == fwp_pkg::FWP_OP_CE);
	endfunction

	// Commands that change array, one-time area or registers
	function automatic logic is_modify(input fwp_pkg::fwp_op_type op);
		is_modify = is_array(op) ||
			(op == fwp_pkg::FWP_OP_OTP) ||
			(op == fwp_pkg::FWP_OP_WRSR) ||
			(op == fwp_pkg::FWP_OP_WRLR);
	endfunction

	// Erase commands, which fill with ones
	function automatic logic is_erase(input fwp_pkg::fwp_op_type op);
		is_erase = (op == fwp_pkg::FWP_OP_SSE) ||
			(op == fwp_pkg::FWP_OP_SE) ||
			(op == fwp_pkg::FWP_OP_CE);
	endfunction

	logic supply_meta_q;
	logic supply_ok_q;
	logic wp_meta_q;
	logic wp_n_q;
	logic wel_q;
	logic tb_q;
	logic [`FWP_BP_W-1:0] bp_q;
	logic [SECTORS-1:0] wlock_q;
	logic [SECTORS-1:0] ldown_q;
	logic grant_q;
	logic refuse_q;
	fwp_pkg::fwp_op_type op_q;
	logic [`FWP_ADDR_W-1:0] addr_q;
	logic [`FWP_ADDR_W-1:0] addr_d;
	logic [7:0] byte_q;
	logic [7:0] byte_d;
	logic [1:0] lock_q;

	// Pin and supply-valid inputs come from outside the clock domain
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			supply_meta_q <= 1'b0;
			supply_ok_q <= 1'b0;
			wp_meta_q <= 1'b0;
			wp_n_q <= 1'b0;
		end else begin
			supply_meta_q <= supply_ok_i;
			supply_ok_q <= supply_meta_q;
			wp_meta_q <= wp_n_i;
			wp_n_q <= wp_meta_q;
		end
	end

	// Address decode into sector and subsector indices
	wire [`FWP_SECT_W-1:0] sector_w = cmd_addr_i[`FWP_SECT_HI:`FWP_SECT_LO];
	wire [`FWP_SECT_HI-`FWP_SUB_LO:0] subsect_w =
		cmd_addr_i[`FWP_SECT_HI:`FWP_SUB_LO];
	wire [`FWP_ADDR_W-1:0] ss_base_w = {subsect_w, 12'h000};
	wire [`FWP_ADDR_W-1:0] se_base_w = cmd_addr_i & ~`FWP_SECT_MASK;

	// Range checker sees the live status bits and the addressed sector
	fwp_range_if rif (
		.clk(clk_i),
		.rst_n(rst_n_i)
	);
	assign rif.tb = tb_q;
	assign rif.bp = bp_q;
	assign rif.sector = sector_w;

	fwp_range_chk u_range (
		.rif(rif)
	);

	// Command classification
	wire op_array = is_array(cmd_op_i);
	wire op_modify = is_modify(cmd_op_i);
	wire op_erase = is_erase(cmd_op_i);
	wire op_ce = (cmd_op_i == fwp_pkg::FWP_OP_CE);
	wire op_wren = (cmd_op_i == fwp_pkg::FWP_OP_WREN);
	wire op_wrdi = (cmd_op_i == fwp_pkg::FWP_OP_WRDI);
	wire op_wrsr = (cmd_op_i == fwp_pkg::FWP_OP_WRSR);
	wire op_wrlr = (cmd_op_i == fwp_pkg::FWP_OP_WRLR);
	wire op_otp = (cmd_op_i == fwp_pkg::FWP_OP_OTP);

	// Guard terms; a partial byte means the frame was cut short
	wire frame_ok = (cmd_bits_i[2:0] == `FWP_BYTE_LSB);
	wire lock_hit = wlock_q[sector_w];
	wire ldown_hit = ldown_q[sector_w];
	wire any_guard = (|wlock_q) || (bp_q != `FWP_BP_NONE);
	wire prot_hit = op_ce ? any_guard : (lock_hit || rif.prot);
	wire otp_ok = (cmd_addr_i < `FWP_OTP_BYTES);

	// Any failing guard stops a modifying command
	wire blocked = !supply_ok_q ||
		!frame_ok ||
		!wel_q ||
		(op_array && prot_hit) ||
		(op_otp && !otp_ok) ||
		(op_wrlr && ldown_hit);
	wire latch_ok = (op_wren || op_wrdi) && supply_ok_q;
	wire grant_d = cmd_valid_i && (op_modify ? !blocked : latch_ok);
	wire refuse_d = cmd_valid_i && op_modify && blocked;
	wire grant_mod = grant_d && op_modify;

	// Status write honours the pin for the range bits and the top/bottom bit alike
	wire sr_wr = grant_d && op_wrsr;
	wire bp_wr = sr_wr && wp_n_q;
	wire lr_wr = grant_d && op_wrlr;

	// Erase addresses snap to their unit, chip erase to zero
	always_comb begin
		case (cmd_op_i)
			fwp_pkg::FWP_OP_SSE: addr_d = ss_base_w;
			fwp_pkg::FWP_OP_SE: addr_d = se_base_w;
			fwp_pkg::FWP_OP_CE: addr_d = `FWP_ADDR_ZERO;
			default: addr_d = cmd_addr_i;
		endcase
	end

	// Program can only pull ones low; erase drives all ones
	assign byte_d = op_erase ? `FWP_ERASED : (old_byte_i & cmd_data_i);

	// Write enable latch, dropped after any executed modification
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wel_q <= 1'b0;
		end else if (grant_d && op_wren) begin
			wel_q <= 1'b1;
		end else if ((grant_d && op_wrdi) || grant_mod) begin
			wel_q <= 1'b0;
		end
	end

	// Status register range bits; nonvolatile image starts at reset value
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bp_q <= `FWP_BP_RST;
			tb_q <= `FWP_TB_RST;
		end else if (bp_wr) begin
			bp_q <= cmd_data_i[`FWP_SR_BP_HI:`FWP_SR_BP_LO];
			tb_q <= cmd_data_i[`FWP_SR_TB];
		end
	end

	// One write-lock and one lock-down bit per sector
	for (genvar i = 0; i < SECTORS; i++) begin : g_lock
		wire hit_w = lr_wr && (sector_w == `FWP_SECT_W'(i));
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				wlock_q[i] <= `FWP_WLOCK_RST;
				ldown_q[i] <= `FWP_LDOWN_RST;
			end else if (hit_w) begin
				wlock_q[i] <= cmd_data_i[`FWP_LR_WLOCK];
				// Lock-down only sets; reset is the sole way out
				ldown_q[i] <= ldown_q[i] | cmd_data_i[`FWP_LR_LDOWN];
			end
		end
	end

	// Verdict and hand-off to the engine, one cycle after the request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			grant_q <= 1'b0;
			refuse_q <= 1'b0;
			op_q <= fwp_pkg::FWP_OP_NONE;
			addr_q <= `FWP_ADDR_ZERO;
			byte_q <= `FWP_ERASED;
		end else begin
			grant_q <= grant_d;
			refuse_q <= refuse_d;
			op_q <= grant_d ? cmd_op_i : fwp_pkg::FWP_OP_NONE;
			addr_q <= grant_d ? addr_d : addr_q;
			byte_q <= grant_d ? byte_d : byte_q;
		end
	end

	// Lock state of the addressed sector, for lock register reads
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_q <= {`FWP_LDOWN_RST, `FWP_WLOCK_RST};
		end else begin
			lock_q <= {ldown_hit, lock_hit};
		end
	end

	assign grant_o = grant_q;
	assign refuse_o = refuse_q;
	assign grant_op_o = op_q;
	assign grant_addr_o = addr_q;
	assign new_byte_o = byte_q;
	assign wel_o = wel_q;
	assign top_bottom_o = tb_q;
	assign range_guard_bits_o = bp_q;
	assign lock_state_o = lock_q;

	// A cut byte never executes a modification
	frame_cut_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_valid_i && is_modify(cmd_op_i) && (cmd_bits_i[2:0] != 3'h0)
		|=> !grant_o && refuse_o)
		else $error("modify with partial byte executed");

	// No latch, no modification; the refused command leaves it clear
	wel_need_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_valid_i && is_modify(cmd_op_i) && !wel_q |=> !grant_o && !wel_q)
		else $error("modify granted without write enable");

	// Nothing is granted before the supply is valid
	supply_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!supply_ok_q && cmd_valid_i |=> !grant_o)
		else $error("command granted with supply invalid");

	// Locked sector refuses program and erase
	sect_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_valid_i && is_array(cmd_op_i) && wlock_q[sector_w]
		|=> refuse_o && (grant_op_o == fwp_pkg::FWP_OP_NONE))
		else $error("program or erase on locked sector");

	// Lock-down freezes the sector's write-lock
	lock_down_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_valid_i && (cmd_op_i == fwp_pkg::FWP_OP_WRLR) && ldown_q[sector_w]
		|=> $stable(wlock_q) && refuse_o)
		else $error("locked-down sector lock changed");

	// Range guard refuses a touching program or erase
	range_guard_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cmd_valid_i && is_array(cmd_op_i) && rif.prot |=> !grant_o)
		else $error("program or erase inside guarded range");

	// Pin low keeps the range bits through a status write
	pin_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!wp_n_q && cmd_valid_i && (cmd_op_i == fwp_pkg::FWP_OP_WRSR)
		|=> $stable(range_guard_bits_o) && $stable(top_bottom_o))
		else $error("range bits changed with pin low");

	// Erase data is all ones, program only clears bits
	fill_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		grant_d && is_erase(cmd_op_i) |=> new_byte_o == 8'hff)
		else $error("erase did not fill with ones");

	prog_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		grant_d && (cmd_op_i == fwp_pkg::FWP_OP_PROG)
		|=> (new_byte_o & ~$past(old_byte_i)) == 8'h00)
		else $error("program raised a bit");

endmodule // fwp_guard

// ==== testbench/fwp_host_model.sv ====
// Host side model that hands commands to the write-protect check
`timescale 1ns/10ps
`include "fwp_defines.svh"

module fwp_host_model (
	input wire logic clk_i,
	output logic cmd_valid_o,
	output fwp_pkg::fwp_op_type cmd_op_o,
	output logic [`FWP_ADDR_W-1:0] cmd_addr_o,
	output logic [15:0] cmd_bits_o,
	output logic [7:0] cmd_data_o
);
	// Idle values at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_op_o = fwp_pkg::FWP_OP_NONE;
		cmd_addr_o = '0;
		cmd_bits_o = 16'h0000;
		cmd_data_o = 8'h00;
	end

	// One request; address held after it so lock state can be read
	task automatic send(fwp_pkg::fwp_op_type op,
		logic [`FWP_ADDR_W-1:0] a, logic [15:0] b, logic [7:0] d);
		@(posedge clk_i);
		#1;
		cmd_op_o = op;
		cmd_addr_o = a;
		cmd_bits_o = b;
		cmd_data_o = d;
		cmd_valid_o = 1'b1;
		@(posedge clk_i);
		#1;
		cmd_valid_o = 1'b0;
		cmd_op_o = fwp_pkg::FWP_OP_NONE;
		// Stale data must not look valid
		cmd_data_o = ~d;
	endtask
endmodule // fwp_host_model

// ==== testbench/test_fwp_guard.sv ====
// Self-checking bench for the write-protect check
`timescale 1ns/10ps
`include "fwp_defines.svh"

module test_fwp_guard;
	logic clk_i, rst_n_i, supply_ok_i, wp_n_i, cmd_valid_i;
	fwp_pkg::fwp_op_type cmd_op_i, grant_op_o;
	logic [24:0] cmd_addr_i, grant_addr_o;
	logic [15:0] cmd_bits_i;
	logic [7:0] cmd_data_i, old_byte_i, new_byte_o;
	logic grant_o, refuse_o, wel_o, top_bottom_o;
	logic [3:0] range_guard_bits_o;
	logic [1:0] lock_state_o;
	int n_errors = 0, total_checks = 0;
	integer seed = 32'h9dc349e5;
	// Reference state
	bit [511:0] lk, ld;
	int wel, tb, bp, sup;
	int secs[9] = '{0, 127, 128, 255, 256, 383, 384, 510, 511};

	fwp_guard fwp_guard_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.supply_ok_i(supply_ok_i), .wp_n_i(wp_n_i),
		.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_addr_i(cmd_addr_i), .cmd_bits_i(cmd_bits_i),
		.cmd_data_i(cmd_data_i), .old_byte_i(old_byte_i),
		.grant_o(grant_o), .refuse_o(refuse_o), .grant_op_o(grant_op_o),
		.grant_addr_o(grant_addr_o), .new_byte_o(new_byte_o),
		.wel_o(wel_o), .top_bottom_o(top_bottom_o),
		.range_guard_bits_o(range_guard_bits_o),
		.lock_state_o(lock_state_o));
	fwp_host_model fwp_host_model_inst (.clk_i(clk_i),
		.cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i),
		.cmd_addr_o(cmd_addr_i), .cmd_bits_o(cmd_bits_i),
		.cmd_data_o(cmd_data_i));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic mreset();
		wel = 0;
		tb = 0;
		bp = 0;
		lk = '1;
		ld = '0;
	endtask

	function automatic int guarded(int s);
		if (bp == 0)
			return 0;
		if (bp >= 10)
			return 1;
		return tb ? s < (1 << (bp - 1)) : s >= 512 - (1 << (bp - 1));
	endfunction

	// Predict, issue, compare; all ops share one path
	task automatic do_cmd(fwp_pkg::fwp_op_type op, int a, int b, int d);
		int s, g, m, ea, eb;
		s = (a >> 16) & 511;
		m = op >= fwp_pkg::FWP_OP_PROG;
		old_byte_i = 8'($random(seed));
		g = sup && (m ? (b % 8 == 0 && wel) : op != fwp_pkg::FWP_OP_NONE);
		ea = a;
		eb = old_byte_i & d & 255;
		if (g)
			case (op)
				fwp_pkg::FWP_OP_PROG: g = !lk[s] && !guarded(s);
				fwp_pkg::FWP_OP_SSE, fwp_pkg::FWP_OP_SE: begin
					g = !lk[s] && !guarded(s);
					ea = a & (op == fwp_pkg::FWP_OP_SE ? 'h1ff0000 : 'h1fff000);
					eb = 255;
				end
				fwp_pkg::FWP_OP_CE: begin
					g = bp == 0 && lk == 0;
					ea = 0;
					eb = 255;
				end
				fwp_pkg::FWP_OP_OTP: g = a < 64;
				fwp_pkg::FWP_OP_WRLR: g = !ld[s];
				default: g = g;
			endcase
		if (g) begin
			wel = op == fwp_pkg::FWP_OP_WREN;
			if (op == fwp_pkg::FWP_OP_WRSR && wp_n_i) begin
				bp = d & 15;
				tb = (d >> 5) & 1;
			end
			if (op == fwp_pkg::FWP_OP_WRLR) begin
				lk[s] = d & 1;
				ld[s] = ld[s] | ((d >> 1) & 1);
			end
		end
		fwp_host_model_inst.send(op, 25'(a), 16'(b), 8'(d));
		chk("grant", grant_o, g);
		chk("refuse", refuse_o, m && !g);
		chk("grant_op", grant_op_o, g ? op : fwp_pkg::FWP_OP_NONE);
		if (g && m && op <= fwp_pkg::FWP_OP_OTP) begin
			chk("grant_addr", grant_addr_o, ea);
			chk("new_byte", new_byte_o, eb);
		end
		@(posedge clk_i);
		#1;
		chk("wel", wel_o, wel);
		chk("top_bottom", top_bottom_o, tb);
		chk("guard_bits", range_guard_bits_o, bp);
		chk("lock_state", lock_state_o, {ld[s], lk[s]});
	endtask

	// Host enables writing before each modifying command
	task automatic do_mod(fwp_pkg::fwp_op_type op, int a, int d);
		do_cmd(fwp_pkg::FWP_OP_WREN, 0, 8, 0);
		do_cmd(op, a, 40, d);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	initial begin
		rst_n_i = 1'b0;
		supply_ok_i = 1'b1;
		wp_n_i = 1'b1;
		old_byte_i = 8'h00;
		sup = 1;
		mreset();
		repeat (6) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		settle();
		chk("lock_state", lock_state_o, 2'b01);
		do_mod(fwp_pkg::FWP_OP_PROG, 'h50000, 'h5a);
		do_cmd(fwp_pkg::FWP_OP_PROG, 'h50000, 40, 'h5a);
		do_mod(fwp_pkg::FWP_OP_WRLR, 'h50000, 0);
		for (int i = 41; i <= 48; i++) begin
			do_cmd(fwp_pkg::FWP_OP_WREN, 0, 8, 0);
			do_cmd(fwp_pkg::FWP_OP_PROG, 'h50000 + i, i, $random(seed));
		end
		for (int i = 3; i <= 5; i++)
			do_mod(fwp_pkg::fwp_op_type'(i), 'h50000 | ($random(seed) & 'hffff),
				$random(seed));
		foreach (secs[k])
			do_mod(fwp_pkg::FWP_OP_WRLR, secs[k] << 16, 0);
		for (int t = 0; t < 2; t++)
			for (int n = 0; n < 16; n++) begin
				do_mod(fwp_pkg::FWP_OP_WRSR, 0, (t << 5) | n);
				foreach (secs[k])
					do_mod(fwp_pkg::FWP_OP_SE, secs[k] << 16, 0);
			end
		wp_n_i = 1'b0;
		settle();
		do_mod(fwp_pkg::FWP_OP_WRSR, 0, 'h03);
		wp_n_i = 1'b1;
		settle();
		do_mod(fwp_pkg::FWP_OP_WRSR, 0, 0);
		do_mod(fwp_pkg::FWP_OP_CE, 0, 0);
		for (int s = 0; s < 512; s++)
			do_mod(fwp_pkg::FWP_OP_WRLR, s << 16, 0);
		do_mod(fwp_pkg::FWP_OP_CE, 0, 0);
		// Disable drops the latch, so the following program is refused
		do_cmd(fwp_pkg::FWP_OP_WREN, 0, 8, 0);
		do_cmd(fwp_pkg::FWP_OP_WRDI, 0, 8, 0);
		do_cmd(fwp_pkg::FWP_OP_PROG, 'h70000, 40, 0);
		do_mod(fwp_pkg::FWP_OP_OTP, 63, $random(seed));
		do_mod(fwp_pkg::FWP_OP_OTP, 64, $random(seed));
		do_mod(fwp_pkg::FWP_OP_WRLR, 'h50000, 3);
		do_mod(fwp_pkg::FWP_OP_WRLR, 'h50000, 0);
		do_mod(fwp_pkg::FWP_OP_PROG, 'h5ffff, 0);
		// Supply drop: synchroniser needs a few edges
		supply_ok_i = 1'b0;
		settle();
		sup = 0;
		do_mod(fwp_pkg::FWP_OP_PROG, 'h60000, 0);
		supply_ok_i = 1'b1;
		settle();
		sup = 1;
		// Mid-run reset restores locks and releases lock-down
		rst_n_i = 1'b0;
		mreset();
		settle();
		rst_n_i = 1'b1;
		settle();
		do_mod(fwp_pkg::FWP_OP_PROG, 'h60000, 0);
		do_mod(fwp_pkg::FWP_OP_WRLR, 'h50000, 0);
		end_of_test();
	end

	// Hang guard, well beyond the expected run
	initial begin
		#(50 * 40000);
		n_errors++;
		end_of_test();
	end
endmodule // test_fwp_guard
